/* File: core/pcg_pkg.sv */
// Purpose: shared constants and types for the peripheral clock gating and power mode block
// Assumes: 16-bit registers on a 32-bit Avalon-MM word bus, word-index addressing
// Notes:   register offsets are word indices; the byte address is four times the index

// ****************************************************************
// package
// ****************************************************************
package pcg_pkg;

	// register word indices
	localparam logic [3:0] REG_GATE_IDX     = 4'hC;
	localparam logic [3:0] REG_SHORT_HI_IDX = 4'hD;
	localparam logic [3:0] REG_SHORT_LO_IDX = 4'hE;
	localparam logic [3:0] REG_MODE_IDX     = 4'hF;

	// peripheral clock gate bit positions
	localparam int GATE_MODULATOR_BIT   = 0;
	localparam int GATE_SPI0_BIT        = 2;
	localparam int GATE_SPI1_BIT        = 3;
	localparam int GATE_ASYNC0_BIT      = 4;
	localparam int GATE_ASYNC1_BIT      = 5;
	localparam int GATE_TIMER1_BIT      = 6;
	localparam int GATE_TIMER3_BIT      = 8;
	localparam int GATE_DECODER_BIT     = 10;
	localparam int GATE_CAN_BIT         = 12;
	localparam int GATE_ANALOG_BIT      = 13;

	// implemented gate bits; the rest are reserved and read as one
	localparam logic [15:0] GATE_IMPL_MASK  = 16'h357D;
	localparam logic [15:0] GATE_RESET      = 16'hFFFF;

	// short I/O address location
	localparam logic [1:0]  SHORT_HI_RESET  = 2'h3;
	localparam logic [15:0] SHORT_LO_RESET  = 16'hFFFF;
	localparam logic [13:0] SHORT_HI_FILL   = 14'h3FFF;
	localparam logic [17:0] SHORT_TOP_OF_MEM = 18'h3FFFF;
	localparam int          SHORT_LOW_BITS  = 6;
	localparam int          SHORT_DELAY_CYC = 5;

	// clocking
	localparam int REF_CLK_MHZ     = 125;
	localparam int MASTER_MAX_MHZ  = 120;
	localparam int SYS_DIVIDE      = 2;

	// power modes
	typedef enum logic [1:0] {
		PCG_RUN,
		PCG_WAIT,
		PCG_STOP
	} pcg_mode_t;

	// mode status register encoding
	localparam logic [1:0] MODE_CODE_RUN  = 2'h0;
	localparam logic [1:0] MODE_CODE_WAIT = 2'h1;
	localparam logic [1:0] MODE_CODE_STOP = 2'h2;

	// events that may end stop mode
	typedef struct packed {
		logic can_activity;
		logic ext_irq;
		logic watchdog_rst;
		logic ext_rst;
		logic por;
	} pcg_wake_t;

endpackage

/* File: core/pcg_top.sv */
// Purpose: peripheral clock gates, short I/O upper address, half-rate clocks, power modes
// Assumes: all inputs synchronous to REF_CLK; gated clocks are built from flip-flops
// Notes:   every clock output is a full-period, flop-driven pulse train at half REF_CLK
//
// Function
// - gate bit one passes clock, zero withholds
// - analog bit 13, CAN 12, decoder 10
// - third timer bit 8, first timer 6
// - second serial bit 5, first 4
// - second SPI bit 3, first SPI 2
// - modulator clock at bit 0
// - reserved gate bits read one, ignore writes
// - low six from instruction, rest from registers
// - high register holds bits 23:22, rest one
// - low register holds bits 21:6, fully writable
// - both short-address registers reset to ones
// - new short address effective after five cycles
// - block debug port if moved and external
// - system clocks at half master rate
// - run keeps core and peripheral clocks
// - wait stops core, memory; interrupt wakes
// - stop exits only on listed wake events
// - peripherals except watchdog use bus clock

`timescale 1ns/1ps

module pcg_top (
	// clock and reset
	input  wire logic               REF_CLK,
	input  wire logic               RST,
	// avalon-mm slave
	input  wire logic [3:0]         AVS_ADDRESS,
	input  wire logic               AVS_READ,
	input  wire logic               AVS_WRITE,
	input  wire logic [31:0]        AVS_WRITEDATA,
	input  wire logic [3:0]         AVS_BYTEENABLE,
	output logic      [31:0]        AVS_READDATA,
	output logic                    AVS_WAITREQUEST,
	// processor core power requests and wake sources
	input  wire logic               ENTER_WAIT,
	input  wire logic               ENTER_STOP,
	input  wire logic               PERIPH_IRQ,
	input  wire pcg_pkg::pcg_wake_t WAKE,
	// short I/O addressing
	input  wire logic [5:0]         SHORT_IO_LOW,
	input  wire logic               EXTERNAL_MEMORY_OPTION,
	output logic      [23:0]        SHORT_IO_ADDR,
	output logic                    DEBUG_PORT_BLOCK,
	// clocks out
	output logic                    CORE_CLK,
	output logic                    MEMORY_CLK,
	output logic                    PERIPHERAL_BUS_CLK,
	output logic                    WATCHDOG_CLK,
	output logic      [15:0]        PERIPHERAL_CLK,
	// mode status
	output logic      [1:0]         POWER_MODE
);

	// ****************************************************************
	// declarations
	// ****************************************************************
	logic                    sys_phase;
	logic [15:0]             peripheral_clock_gate;
	logic [15:0]             gate_hold;
	logic [1:0]              short_io_address_high;
	logic [15:0]             short_io_address_low;
	logic [17:0]             short_pipe [pcg_pkg::SHORT_DELAY_CYC];
	logic [17:0]             short_io_upper_address;
	pcg_pkg::pcg_mode_t      mode;
	pcg_pkg::pcg_mode_t      next_mode;
	logic                    bus_access;
	logic                    wr_take;
	logic [15:0]             next_readdata;
	logic                    periph_run;
	logic                    core_run;

	// ****************************************************************
	// functions
	// ****************************************************************

	// merge a 16-bit write through the two low byte lanes
	function automatic logic [15:0] lane_merge(
		input logic [15:0] old_val,
		input logic [31:0] wdata,
		input logic [3:0]  be
	);
		logic [15:0] res;
		res = old_val;
		if (be[0]) begin
			res[7:0] = wdata[7:0];
		end
		if (be[1]) begin
			res[15:8] = wdata[15:8];
		end
		return res;
	endfunction

	// mode to status code
	function automatic logic [1:0] mode_code(input pcg_pkg::pcg_mode_t m);
		logic [1:0] c;
		c = pcg_pkg::MODE_CODE_RUN;
		unique case (m)
			pcg_pkg::PCG_RUN: begin
				c = pcg_pkg::MODE_CODE_RUN;
			end
			pcg_pkg::PCG_WAIT: begin
				c = pcg_pkg::MODE_CODE_WAIT;
			end
			pcg_pkg::PCG_STOP: begin
				c = pcg_pkg::MODE_CODE_STOP;
			end
			default: begin
				c = pcg_pkg::MODE_CODE_RUN;
			end
		endcase
		return c;
	endfunction

	// ****************************************************************
	// avalon-mm slave
	// ****************************************************************

	// one wait cycle then a single-cycle answer; waitrequest idles high
	assign bus_access = AVS_READ | AVS_WRITE;
	assign wr_take    = AVS_WRITE & ~AVS_WAITREQUEST;

	// read mux; unmapped indices read zero
	always_comb begin
		next_readdata = 16'h0000;
		unique case (AVS_ADDRESS)
			pcg_pkg::REG_GATE_IDX: begin
				next_readdata = peripheral_clock_gate | ~pcg_pkg::GATE_IMPL_MASK;
			end
			pcg_pkg::REG_SHORT_HI_IDX: begin
				next_readdata = {pcg_pkg::SHORT_HI_FILL, short_io_address_high};
			end
			pcg_pkg::REG_SHORT_LO_IDX: begin
				next_readdata = short_io_address_low;
			end
			pcg_pkg::REG_MODE_IDX: begin
				next_readdata = {14'h0000, mode_code(mode)};
			end
			default: begin
				next_readdata = 16'h0000;
			end
		endcase
	end

	// handshake: drop waitrequest for exactly one cycle per request
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			AVS_WAITREQUEST <= 1'b1;
			AVS_READDATA    <= 32'h0000_0000;
		end else begin
			if (bus_access && AVS_WAITREQUEST) begin
				AVS_WAITREQUEST <= 1'b0;
				AVS_READDATA    <= {16'h0000, next_readdata};
			end else begin
				AVS_WAITREQUEST <= 1'b1;
			end
		end
	end

	// ****************************************************************
	// registers
	// ****************************************************************

	// peripheral clock gate; reserved bits hold one and ignore writes
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			peripheral_clock_gate <= pcg_pkg::GATE_RESET;
		end else if (wr_take && AVS_ADDRESS == pcg_pkg::REG_GATE_IDX) begin
			peripheral_clock_gate <= (lane_merge(peripheral_clock_gate, AVS_WRITEDATA,
				AVS_BYTEENABLE) & pcg_pkg::GATE_IMPL_MASK) | ~pcg_pkg::GATE_IMPL_MASK;
		end
	end

	// short-address location pair, all ones after reset
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			short_io_address_high <= pcg_pkg::SHORT_HI_RESET;
			short_io_address_low  <= pcg_pkg::SHORT_LO_RESET;
		end else if (wr_take) begin
			if (AVS_ADDRESS == pcg_pkg::REG_SHORT_HI_IDX && AVS_BYTEENABLE[0]) begin
				short_io_address_high <= AVS_WRITEDATA[1:0];
			end
			if (AVS_ADDRESS == pcg_pkg::REG_SHORT_LO_IDX) begin
				short_io_address_low <= lane_merge(short_io_address_low, AVS_WRITEDATA,
					AVS_BYTEENABLE);
			end
		end
	end

	// ****************************************************************
	// short I/O addressing
	// ****************************************************************

	// the stored value reaches the address path only after five stages,
	// so software that uses it sooner still sees the old page
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			for (int i = 0; i < pcg_pkg::SHORT_DELAY_CYC; i++) begin
				short_pipe[i] <= pcg_pkg::SHORT_TOP_OF_MEM;
			end
		end else begin
			short_pipe[0] <= {short_io_address_high, short_io_address_low};
			for (int i = 1; i < pcg_pkg::SHORT_DELAY_CYC; i++) begin
				short_pipe[i] <= short_pipe[i-1];
			end
		end
	end

	assign short_io_upper_address = short_pipe[pcg_pkg::SHORT_DELAY_CYC-1];

	// full address and debug port lock
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			SHORT_IO_ADDR    <= {pcg_pkg::SHORT_TOP_OF_MEM, 6'h00};
			DEBUG_PORT_BLOCK <= 1'b0;
		end else begin
			SHORT_IO_ADDR    <= {short_io_upper_address, SHORT_IO_LOW};
			DEBUG_PORT_BLOCK <= (short_io_upper_address != pcg_pkg::SHORT_TOP_OF_MEM)
				&& EXTERNAL_MEMORY_OPTION;
		end
	end

	// ****************************************************************
	// power modes
	// ****************************************************************

	// entry only from run; stop ignores peripheral interrupts
	always_comb begin
		next_mode = mode;
		unique case (mode)
			pcg_pkg::PCG_RUN: begin
				if (ENTER_STOP) begin
					next_mode = pcg_pkg::PCG_STOP;
				end else if (ENTER_WAIT) begin
					next_mode = pcg_pkg::PCG_WAIT;
				end
			end
			pcg_pkg::PCG_WAIT: begin
				if (PERIPH_IRQ) begin
					next_mode = pcg_pkg::PCG_RUN;
				end
			end
			pcg_pkg::PCG_STOP: begin
				if (|WAKE) begin
					next_mode = pcg_pkg::PCG_RUN;
				end
			end
			default: begin
				next_mode = pcg_pkg::PCG_RUN;
			end
		endcase
	end

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			mode       <= pcg_pkg::PCG_RUN;
			POWER_MODE <= pcg_pkg::MODE_CODE_RUN;
		end else begin
			mode       <= next_mode;
			POWER_MODE <= mode_code(next_mode);
		end
	end

	// the CAN unit is unclocked in stop, so the waking frame is lost
	assign core_run   = (mode == pcg_pkg::PCG_RUN);
	assign periph_run = (mode != pcg_pkg::PCG_STOP);

	// ****************************************************************
	// clock generation
	// ****************************************************************

	// divide by two; REF_CLK stands in for a master clock of at most 120 MHz
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			sys_phase <= 1'b0;
		end else begin
			sys_phase <= ~sys_phase;
		end
	end

	// system clocks: each high phase is either whole or absent
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			CORE_CLK           <= 1'b0;
			MEMORY_CLK         <= 1'b0;
			PERIPHERAL_BUS_CLK <= 1'b0;
			WATCHDOG_CLK       <= 1'b0;
		end else begin
			CORE_CLK           <= ~sys_phase & core_run;
			MEMORY_CLK         <= ~sys_phase & core_run;
			PERIPHERAL_BUS_CLK <= ~sys_phase & periph_run;
			WATCHDOG_CLK       <= ~sys_phase;
		end
	end

	// per-peripheral gates, enable sampled only at the end of the high phase
	generate
		for (genvar g = 0; g < 16; g++) begin : gen_gate
			if (pcg_pkg::GATE_IMPL_MASK[g]) begin : gen_impl
				// hold stands in for the latch of a gating cell; it moves
				// only when the output is about to go low
				always_ff @(posedge REF_CLK) begin
					if (RST) begin
						gate_hold[g] <= 1'b0;
					end else if (sys_phase) begin
						gate_hold[g] <= peripheral_clock_gate[g];
					end
				end
				// bus clock derived, so peripherals share its frequency
				always_ff @(posedge REF_CLK) begin
					if (RST) begin
						PERIPHERAL_CLK[g] <= 1'b0;
					end else begin
						PERIPHERAL_CLK[g] <= ~sys_phase & periph_run
							& gate_hold[g];
					end
				end
			end else begin : gen_resv
				// reserved lanes never toggle
				always_ff @(posedge REF_CLK) begin
					gate_hold[g]      <= 1'b0;
					PERIPHERAL_CLK[g] <= 1'b0;
				end
			end
		end
	endgenerate

endmodule

/* File: bench/pcg_chk_sva.sv */
// Purpose: port-level assertions for the clock gating and power mode block
// Assumes: one clock domain, synchronous active-high reset
// Notes:   attached to every pcg_top by the bind at the foot
`timescale 1ns/1ps
// ****************
// checker
// ****************
module pcg_chk (
	// clock and reset
	input wire logic               REF_CLK,
	input wire logic               RST,
	// register bus
	input wire logic [3:0]         AVS_ADDRESS,
	input wire logic               AVS_READ,
	input wire logic               AVS_WRITE,
	input wire logic [31:0]        AVS_WRITEDATA,
	input wire logic [31:0]        AVS_READDATA,
	input wire logic               AVS_WAITREQUEST,
	// wake sources
	input wire logic               PERIPH_IRQ,
	input wire pcg_pkg::pcg_wake_t WAKE,
	// short addressing
	input wire logic               EXTERNAL_MEMORY_OPTION,
	input wire logic [23:0]        SHORT_IO_ADDR,
	input wire logic               DEBUG_PORT_BLOCK,
	// clocks and mode
	input wire logic               CORE_CLK,
	input wire logic               MEMORY_CLK,
	input wire logic               PERIPHERAL_BUS_CLK,
	input wire logic               WATCHDOG_CLK,
	input wire logic [15:0]        PERIPHERAL_CLK,
	input wire logic [1:0]         POWER_MODE
);
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (RST);

	// register views
	a_gate_rsv_ones: assert property (
		AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS == pcg_pkg::REG_GATE_IDX
		|-> &(AVS_READDATA[15:0] | pcg_pkg::GATE_IMPL_MASK)) else $error("gate reserved bit low");
	// the new location must not leak out early: held one more cycle, then it lands
	a_short_delay: assert property (
		AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == pcg_pkg::REG_SHORT_LO_IDX
		|-> ##6 $stable(SHORT_IO_ADDR[21:6]) ##1 SHORT_IO_ADDR[21:6] == $past(AVS_WRITEDATA[15:0], 7))
		else $error("short address timing wrong");
	a_debug_block: assert property (
		!$past(RST) |-> DEBUG_PORT_BLOCK == ($past(EXTERNAL_MEMORY_OPTION)
		&& SHORT_IO_ADDR[23:6] != pcg_pkg::SHORT_TOP_OF_MEM)) else $error("debug block wrong");

	// clocks per mode; the repetition skips the one cycle a clock needs to restart
	a_run_clocks: assert property (
		(POWER_MODE == pcg_pkg::MODE_CODE_RUN)[*3] |-> CORE_CLK != $past(CORE_CLK)
		&& PERIPHERAL_BUS_CLK != $past(PERIPHERAL_BUS_CLK)) else $error("run clock stalled");
	a_wait_clocks: assert property (
		(POWER_MODE == pcg_pkg::MODE_CODE_WAIT)[*2] |-> !CORE_CLK && !MEMORY_CLK
		&& PERIPHERAL_BUS_CLK != $past(PERIPHERAL_BUS_CLK)) else $error("wait clocks wrong");
	a_wait_wake: assert property (
		POWER_MODE == pcg_pkg::MODE_CODE_WAIT && PERIPH_IRQ
		|=> POWER_MODE == pcg_pkg::MODE_CODE_RUN) else $error("interrupt did not wake");
	a_stop_exit: assert property (
		POWER_MODE == pcg_pkg::MODE_CODE_STOP |=> POWER_MODE == (($past(WAKE) != '0)
		? pcg_pkg::MODE_CODE_RUN : pcg_pkg::MODE_CODE_STOP)) else $error("stop exit wrong");
	a_watchdog_free: assert property (
		!$past(RST) && !$past(RST, 2) |-> WATCHDOG_CLK != $past(WATCHDOG_CLK))
		else $error("watchdog clock stalled");

	// a gated pulse outside a bus pulse would mean a truncated or shifted edge
	a_gate_aligned: assert property (
		(PERIPHERAL_CLK & ~{16{PERIPHERAL_BUS_CLK}}) == 16'h0000)
		else $error("gated clock outside bus pulse");
	a_rsv_silent: assert property (
		(PERIPHERAL_CLK & ~pcg_pkg::GATE_IMPL_MASK) == 16'h0000)
		else $error("reserved lane clocked");
endmodule

bind pcg_top pcg_chk chk_u (.*);

/* File: bench/pcg_periph_model.sv */
// Purpose: far-side model of the peripherals, memories and core clock inputs
// Assumes: each consumer acts on the rising edge of its own clock
// Notes:   edges found against REF_CLK, as every clock out is flop-driven
`timescale 1ns/1ps
// ****************
// model
// ****************
module pcg_periph_model (
	// reference clock and counter clear
	input wire logic        ref_clk,
	input wire logic        clr,
	// gated 15:0, core, memory, bus, watchdog
	input wire logic [19:0] clks
);
	logic [19:0] prev;
	int          cnt [20];

	// a consumer only sees edges it gets; a held clock leaves its count still
	always_ff @(posedge ref_clk) begin
		prev <= clks;
		for (int i = 0; i < 20; i++) begin
			if (clr)
				cnt[i] <= 0;
			else if (clks[i] && !prev[i])
				cnt[i] <= cnt[i] + 1;
		end
	end
endmodule

/* File: bench/tb_top.sv */
// Purpose: self-checking bench for the clock gating and power mode block
// Assumes: one wait cycle per bus access, clocks at half rate
// Notes:   clock activity is judged by edge counts in the model
`timescale 1ns/1ps
// ****************
// bench
// ****************
module tb_top;
	typedef struct packed {
		logic [3:0]  a;
		logic [15:0] d;
		logic [15:0] e;
	} pcg_row_t;
	// address, write data, read back
	pcg_row_t           rows [17] = '{
		36'hC0000CA82, 36'hC2000EA82, 36'hC1000DA82, 36'hC0400CE82,
		36'hC0100CB82, 36'hC0040CAC2, 36'hC0020CAA2, 36'hC0010CA92,
		36'hC0008CA8A, 36'hC0004CA86, 36'hC0001CA83, 36'hCFFFFFFFF,
		36'hD0000FFFC, 36'hD0002FFFE, 36'hE12341234, 36'h0FFFF0000, 36'hFFFFF0000};
	logic               ref_clk = 1'h0;
	logic               rst = 1'h1;
	logic [3:0]         addr = 4'h0;
	logic               rd = 1'h0;
	logic               wr = 1'h0;
	logic [31:0]        wdata = 32'h0;
	logic               ent_wait = 1'h0;
	logic               ent_stop = 1'h0;
	logic               irq = 1'h0;
	pcg_pkg::pcg_wake_t wake = '0;
	logic [5:0]         io_low = 6'h00;
	logic               ext_opt = 1'h0;
	logic               clr = 1'h0;
	logic [31:0]        rdata;
	logic [31:0]        q;
	logic               waitreq;
	logic [23:0]        io_addr;
	logic               dbg_blk;
	logic [1:0]         mode;
	logic [15:0]        on;
	wire  [19:0]        clks;
	int                 n_mismatch = 0;
	int                 compares = 0;

	always #4 ref_clk = ~ref_clk;

	pcg_top dut_u (
		.REF_CLK(ref_clk), .RST(rst), .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
		.AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(4'hF), .AVS_READDATA(rdata),
		.AVS_WAITREQUEST(waitreq), .ENTER_WAIT(ent_wait), .ENTER_STOP(ent_stop),
		.PERIPH_IRQ(irq), .WAKE(wake), .SHORT_IO_LOW(io_low), .EXTERNAL_MEMORY_OPTION(ext_opt),
		.SHORT_IO_ADDR(io_addr), .DEBUG_PORT_BLOCK(dbg_blk), .CORE_CLK(clks[16]),
		.MEMORY_CLK(clks[17]), .PERIPHERAL_BUS_CLK(clks[18]), .WATCHDOG_CLK(clks[19]),
		.PERIPHERAL_CLK(clks[15:0]), .POWER_MODE(mode));
	pcg_periph_model model_u (.ref_clk(ref_clk), .clr(clr), .clks(clks));

	task automatic complete_run();
		if (n_mismatch == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		compares++;
		if (s !== e) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	// request held until waitrequest is seen low at an edge
	task automatic bus(input logic w, input logic [3:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		rd <= !w;
		wr <= w;
		addr <= a;
		wdata <= {16'h0000, d};
		do @(posedge ref_clk); while (waitreq !== 1'h0);
		q = rdata;
		rd <= 1'h0;
		wr <= 1'h0;
	endtask
	// clear the counters, then let n cycles of clocks arrive
	task automatic count(input int n);
		clr <= 1'h1;
		idle(1);
		clr <= 1'h0;
		idle(n);
	endtask

	// hang guard, far beyond the few hundred cycles needed
	initial begin
		idle(20000);
		n_mismatch++;
		complete_run();
	end

	initial begin
		idle(2);
		rst <= 1'h0;
		foreach (rows[i]) begin
			bus(1'h1, rows[i].a, rows[i].d);
			bus(1'h0, rows[i].a, 16'h0000);
			chk("reg", {16'h0000, rows[i].e}, q);
			count(12);
			for (int b = 0; b < 16; b++)
				on[b] = model_u.cnt[b] > 0;
			if (rows[i].a == pcg_pkg::REG_GATE_IDX)
				chk("gate clk", 32'(rows[i].e & pcg_pkg::GATE_IMPL_MASK), 32'(on));
		end
		// short address and debug port blocking
		io_low <= 6'h2A;
		ext_opt <= 1'h1;
		idle(3);
		chk("short addr", 32'h00848D2A, {8'h00, io_addr});
		chk("dbg block", 32'h1, {31'h0, dbg_blk});
		ext_opt <= 1'h0;
		idle(2);
		chk("dbg block", 32'h0, {31'h0, dbg_blk});
		// second reset in mid-run
		ext_opt <= 1'h1;
		rst <= 1'h1;
		idle(2);
		rst <= 1'h0;
		for (int a = 12; a < 15; a++) begin
			bus(1'h0, 4'(a), 16'h0000);
			chk("reset val", 32'h0000FFFF, q);
		end
		chk("reset addr", 32'h00FFFFEA, {8'h00, io_addr});
		chk("dbg block", 32'h0, {31'h0, dbg_blk});
		// wait halts core and memory only; an interrupt wakes
		ent_wait <= 1'h1;
		idle(1);
		ent_wait <= 1'h0;
		count(10);
		chk("mode", 32'h1, {30'h0, mode});
		chk("core edges", 32'h0, 32'(model_u.cnt[16] + model_u.cnt[17]));
		chk("bus alive", 32'h1, 32'(model_u.cnt[18] > 0));
		irq <= 1'h1;
		idle(1);
		irq <= 1'h0;
		count(10);
		chk("mode", 32'h0, {30'h0, mode});
		chk("core alive", 32'h1, 32'(model_u.cnt[16] > 0 && model_u.cnt[17] > 0));
		// stop beats wait and ignores interrupts
		ent_wait <= 1'h1;
		ent_stop <= 1'h1;
		idle(1);
		ent_wait <= 1'h0;
		ent_stop <= 1'h0;
		irq <= 1'h1;
		idle(1);
		irq <= 1'h0;
		count(10);
		chk("mode", 32'h2, {30'h0, mode});
		chk("bus edges", 32'h0, 32'(model_u.cnt[18]));
		chk("watchdog", 32'h1, 32'(model_u.cnt[19] > 0));
		// each wake source alone ends stop
		for (int w = 0; w < 5; w++) begin
			wake <= 5'h01 << w;
			idle(1);
			wake <= '0;
			idle(2);
			chk("wake", 32'h0, {30'h0, mode});
			ent_stop <= 1'h1;
			idle(1);
			ent_stop <= 1'h0;
			idle(2);
		end
		complete_run();
	end
endmodule
